// ==== rtl/rspc_pkg.sv ====
// Package of constants and carrier types for the reset strap loader
// Summary of operation
// - Four flags configurable, inputs after reset
// - Request pins interrupt, edge or level each
// - Request pins disabled after reset unless strapped
// - Timer expiry gives four-cycle output pulse
// - Direction output 0 receive, 1 transmit
// - Impedance code decodes to two control flags
// - Flag 0 maximum strength, 1 uses select
// - Select value n gives strength n
// - Priority and emulation outputs always strength 7
// - Strap pins sampled while reset active
// - Undriven strap reads default zero
// - Boot strap 0 boots EPROM, 1 idles
// - Enable strap 1 edge enabled, 0 disabled level
package rspc_pkg;
    localparam int NUM_FLAGS = 4;
    localparam int NUM_IRQS = 4;
    localparam int NUM_LINKS = 4;
    localparam int STRENGTH_W = 3;
    localparam int PULSE_CYCLES = 4;
    localparam logic [2:0] PULSE_LAST = 3'h3;
    localparam logic [2:0] STRENGTH_MAX = 3'h7;
    localparam logic [2:0] STRENGTH_DEFAULT = 3'h7;
    localparam logic [2:0] IMP_OFF_A = 3'h0;
    localparam logic [2:0] IMP_OFF_B = 3'h1;
    localparam logic [2:0] IMP_LINK_ONLY = 3'h2;
    localparam logic [2:0] IMP_ADC_ONLY = 3'h4;
    localparam logic [2:0] IMP_BOTH = 3'h6;
    localparam logic STRAP_DEFAULT = 1'b0;

    typedef struct packed {
        logic bootExternal;
        logic irqEnable;
        logic testOne;
        logic testTwo;
    } rspc_straps_t;

    typedef struct packed {
        logic [2:0] adcStrength;
        logic [2:0] linkStrength;
        logic [2:0] fixedStrength;
        logic adcDigCtrl;
        logic linkDigCtrl;
        logic impReserved;
    } rspc_drive_t;
endpackage

// ==== rtl/rspc_pulse_gen.sv ====
// Fixed-length pulse generator for the timer-expired output
`timescale 1ns/1ps
module rspc_pulse_gen
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Trigger and pulse
    input wire logic trigger,
    output logic pulse
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic next_pulse;

    // A trigger during a pulse restarts it, so it never gets cut short
    always_comb
    begin
        next_count = count;
        next_pulse = pulse;
        if (trigger)
        begin
            next_count = 3'h0;
            next_pulse = 1'b1;
        end
        else if (pulse)
        begin
            if (count == rspc_pkg::PULSE_LAST)
                next_pulse = 1'b0;
            else
                next_count = count + 3'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            count <= 3'h0;
            pulse <= 1'b0;
        end
        else
        begin
            count <= next_count;
            pulse <= next_pulse;
        end
    end
endmodule

// ==== rtl/rspc_strap_config.sv ====
// Top of the reset strap loader: straps, drive decode, pins, interrupts
`timescale 1ns/1ps
module rspc_strap_config
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Strap carrier pins, read while reset is low
    input wire logic boot_memory_select_pin,
    input wire logic interrupt_strap_carrier_pin,
    input wire logic port_two_direction_in,
    input wire logic timer_zero_expired_in,
    // Static selection pins
    input wire logic [2:0] impedance_select_pins,
    input wire logic [2:0] drive_strength_select,
    // Program condition pins
    input wire logic [3:0] program_condition_in,
    input wire logic [3:0] flagDirection,
    input wire logic [3:0] flagWriteValue,
    output logic [3:0] program_condition_out,
    output logic [3:0] program_condition_oe,
    output logic [3:0] flagReadValue,
    // Interrupt requests, active low pins
    input wire logic [3:0] interrupt_request_pins_n,
    input wire logic irqConfigWrite,
    input wire logic [3:0] irqEnableSet,
    input wire logic [3:0] irqEdgeSet,
    input wire logic [3:0] irqAck,
    output logic [3:0] irqPending,
    output logic [3:0] irqEnabled,
    output logic [3:0] irqEdgeMode,
    // Timer and link direction
    input wire logic timerZeroExpire,
    input wire logic [3:0] linkTransmit,
    output logic timer_zero_expired_out,
    output logic port_zero_direction_out,
    output logic [2:0] portUpperDirection,
    // Strap results and drive settings
    output rspc_pkg::rspc_straps_t straps,
    output logic bootFromEprom,
    output logic bootWaitExternal,
    output rspc_pkg::rspc_drive_t drive
);
    // ****************************************************************
    // Strap capture
    // ****************************************************************
    rspc_pkg::rspc_straps_t sampled;
    rspc_pkg::rspc_straps_t next_sampled;
    rspc_pkg::rspc_straps_t next_straps;
    logic inReset;

    // Pins are tracked all through reset; the last value is kept
    always_comb
    begin
        next_sampled = sampled;
        next_straps = straps;
        if (!rst_n)
        begin
            next_sampled.bootExternal = boot_memory_select_pin;
            next_sampled.irqEnable = interrupt_strap_carrier_pin;
            next_sampled.testOne = port_two_direction_in;
            next_sampled.testTwo = timer_zero_expired_in;
        end
        else if (inReset)
            next_straps = sampled;
    end

    always_ff @(posedge core_clk)
    begin
        sampled <= next_sampled;
        inReset <= !rst_n;
        straps <= next_straps;
    end

    // ****************************************************************
    // Boot mode
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || inReset)
        begin
            bootFromEprom <= 1'b0;
            bootWaitExternal <= 1'b0;
        end
        else
        begin
            // Default zero on an open pin selects EPROM boot
            bootFromEprom <= !straps.bootExternal;
            bootWaitExternal <= straps.bootExternal;
        end
    end

    // ****************************************************************
    // Drive strength decode
    // ****************************************************************
    rspc_pkg::rspc_drive_t next_drive;

    always_comb
    begin
        next_drive = '0;
        unique case (impedance_select_pins)
            rspc_pkg::IMP_OFF_A, rspc_pkg::IMP_OFF_B:
            begin
                next_drive.adcDigCtrl = 1'b0;
                next_drive.linkDigCtrl = 1'b0;
            end
            rspc_pkg::IMP_LINK_ONLY: next_drive.linkDigCtrl = 1'b1;
            rspc_pkg::IMP_ADC_ONLY: next_drive.adcDigCtrl = 1'b1;
            rspc_pkg::IMP_BOTH:
            begin
                next_drive.adcDigCtrl = 1'b1;
                next_drive.linkDigCtrl = 1'b1;
            end
            // Reserved codes fall back to maximum drive, flagged
            default: next_drive.impReserved = 1'b1;
        endcase
        next_drive.adcStrength = rspc_pkg::STRENGTH_MAX;
        next_drive.linkStrength = rspc_pkg::STRENGTH_MAX;
        if (next_drive.adcDigCtrl)
            next_drive.adcStrength = drive_strength_select;
        if (next_drive.linkDigCtrl)
            next_drive.linkStrength = drive_strength_select;
        next_drive.fixedStrength = rspc_pkg::STRENGTH_MAX;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            drive <= '0;
            drive.adcStrength <= rspc_pkg::STRENGTH_MAX;
            drive.linkStrength <= rspc_pkg::STRENGTH_MAX;
            drive.fixedStrength <= rspc_pkg::STRENGTH_MAX;
        end
        else
            drive <= next_drive;
    end

    // ****************************************************************
    // Program condition pins
    // ****************************************************************
    logic [3:0] next_flagOe;

    always_comb
    begin
        next_flagOe = flagDirection;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            program_condition_oe <= 4'h0;
            program_condition_out <= 4'h0;
            flagReadValue <= 4'h0;
        end
        else
        begin
            program_condition_oe <= next_flagOe;
            program_condition_out <= flagWriteValue;
            flagReadValue <= program_condition_in;
        end
    end

    // ****************************************************************
    // Interrupt requests
    // ****************************************************************
    logic [3:0] reqLevel;
    logic [3:0] reqPrev;
    logic [3:0] next_pending;
    logic [3:0] next_enabled;
    logic [3:0] next_edge;

    always_comb
    begin
        reqLevel = ~interrupt_request_pins_n;
        next_enabled = irqEnabled;
        next_edge = irqEdgeMode;
        if (inReset)
        begin
            // Straps load on this same edge, so read the captured copy
            next_enabled = {4{sampled.irqEnable}};
            next_edge = {4{sampled.irqEnable}};
        end
        else if (irqConfigWrite)
        begin
            next_enabled = irqEnableSet;
            next_edge = irqEdgeSet;
        end
        next_pending = irqPending;
        for (int i = 0; i < rspc_pkg::NUM_IRQS; i++)
        begin
            if (!irqEdgeMode[i])
                next_pending[i] = reqLevel[i] & irqEnabled[i];
            else
            begin
                if (irqAck[i])
                    next_pending[i] = 1'b0;
                // Set wins over a same-cycle acknowledge
                if (reqLevel[i] & ~reqPrev[i] & irqEnabled[i])
                    next_pending[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            irqEnabled <= 4'h0;
            irqEdgeMode <= 4'h0;
            irqPending <= 4'h0;
            reqPrev <= 4'h0;
        end
        else
        begin
            irqEnabled <= next_enabled;
            irqEdgeMode <= next_edge;
            irqPending <= next_pending;
            reqPrev <= reqLevel;
        end
    end

    // ****************************************************************
    // Timer pulse and link directions
    // ****************************************************************
    rspc_pulse_gen u_pulse
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .trigger(timerZeroExpire),
        .pulse(timer_zero_expired_out)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            port_zero_direction_out <= 1'b0;
            portUpperDirection <= 3'h0;
        end
        else
        begin
            port_zero_direction_out <= linkTransmit[0];
            portUpperDirection <= linkTransmit[3:1];
        end
    end
endmodule

// ==== test/rspc_strap_config_assertions.sv ====
// Port-level assertions for the reset strap loader
`timescale 1ns/1ps
module rspc_strap_config_assertions
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched pins and results
    input wire logic [2:0] impedance_select_pins,
    input wire logic [2:0] drive_strength_select,
    input wire logic [3:0] flagDirection,
    input wire logic [3:0] program_condition_oe,
    input wire logic [3:0] irqEnabled,
    input wire logic [3:0] irqEdgeMode,
    input wire logic timerZeroExpire,
    input wire logic timer_zero_expired_out,
    input wire rspc_pkg::rspc_straps_t straps,
    input wire logic bootFromEprom,
    input wire logic bootWaitExternal,
    input wire rspc_pkg::rspc_drive_t drive
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Reserved codes leave both flags open, so only the marker is fixed
    function automatic logic [2:0] dec(logic [2:0] c);
        return (c[0] && c[2:1] != 2'h0) ? 3'h1 : {c[2], c[1], 1'h0};
    endfunction
    a_pulse_length: assert property (timerZeroExpire |=>
        timer_zero_expired_out [*4]) else $error("pulse short");
    a_pulse_end: assert property (timerZeroExpire ##1
        !timerZeroExpire [*4] |=> !timer_zero_expired_out)
        else $error("pulse long");
    a_flag_dir: assert property ($past(rst_n) |->
        program_condition_oe == $past(flagDirection)) else $error("flag oe");
    a_imp_decode: assert property ($past(rst_n) |->
        {drive.adcDigCtrl & !drive.impReserved, drive.linkDigCtrl &
        !drive.impReserved, drive.impReserved} ==
        dec($past(impedance_select_pins))) else $error("imp decode");
    a_strength_sel: assert property ($past(rst_n) |->
        drive.adcStrength == (drive.adcDigCtrl && !drive.impReserved ?
        $past(drive_strength_select) : 3'h7) && drive.linkStrength ==
        (drive.linkDigCtrl && !drive.impReserved ?
        $past(drive_strength_select) : 3'h7)) else $error("strength");
    a_fixed_strength: assert property (
        drive.fixedStrength == 3'h7) else $error("fixed strength");
    a_strap_held: assert property ($past(rst_n) &&
        $past(rst_n, 2) |-> $stable(straps)) else $error("straps moved");
    a_boot_decode: assert property ($past(rst_n) &&
        $past(rst_n, 2) |-> {bootFromEprom, bootWaitExternal} ==
        {!straps.bootExternal, straps.bootExternal}) else $error("boot");
    a_irq_strap: assert property ($past(rst_n) &&
        $past(rst_n, 2) && !$past(rst_n, 3) |-> {irqEnabled, irqEdgeMode}
        == {8{straps.irqEnable}}) else $error("irq strap");
endmodule

bind rspc_strap_config rspc_strap_config_assertions u_chk (.*);

// ==== test/rspc_board_model.sv ====
// Board model: strap resistors and interrupt sources
`timescale 1ns/1ps
module rspc_board_model
(
    // Commands from the bench
    input wire logic pullBoot,
    input wire logic pullIrq,
    input wire logic [3:0] irqAssert,
    // Pins toward the device
    output logic boot_memory_select_pin,
    output logic interrupt_strap_carrier_pin,
    output logic port_two_direction_in,
    output logic timer_zero_expired_in,
    output logic [3:0] interrupt_request_pins_n
);
    // Unloaded straps fall to the pull-down level
    assign boot_memory_select_pin = pullBoot;
    assign interrupt_strap_carrier_pin = pullIrq;
    assign port_two_direction_in = 1'h0;
    assign timer_zero_expired_in = 1'h0;
    // Requests idle high on the pull-up
    assign interrupt_request_pins_n = ~irqAssert;
endmodule

// ==== test/rspc_strap_config_tb.sv ====
// Self-checking bench for the reset strap loader
`timescale 1ns/1ps
module rspc_strap_config_tb;
    logic core_clk, rst_n, pullBoot, pullIrq, irqConfigWrite;
    logic timerZeroExpire, boot_memory_select_pin, bootFromEprom;
    logic interrupt_strap_carrier_pin, port_two_direction_in;
    logic timer_zero_expired_in, bootWaitExternal, timer_zero_expired_out;
    logic port_zero_direction_out;
    logic [2:0] impedance_select_pins, drive_strength_select;
    logic [2:0] portUpperDirection;
    logic [3:0] irqAssert, interrupt_request_pins_n, flagDirection;
    logic [3:0] flagWriteValue, program_condition_in, program_condition_out;
    logic [3:0] program_condition_oe, flagReadValue, irqEnableSet;
    logic [3:0] irqEdgeSet, irqAck, irqPending, irqEnabled, irqEdgeMode;
    logic [3:0] linkTransmit, seenDir;
    logic [11:0] expDrive;
    rspc_pkg::rspc_straps_t straps;
    rspc_pkg::rspc_drive_t drive;
    int bad_count, n_checks, cyc, seed;

    rspc_board_model i_board (.*);
    rspc_strap_config i_dut (.*);

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk(string n, logic [11:0] e, logic [11:0] s);
        n_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Reserved codes force full strength
    function automatic logic [11:0] exp_drv(logic [2:0] c, logic [2:0] s);
        logic a, l, r;
        r = c[0] && c[2:1] != 2'h0;
        a = !r && c[2];
        l = !r && c[1];
        return {a ? s : 3'h7, l ? s : 3'h7, 3'h7, a, l, r};
    endfunction

    // Pins swap after release to show the latched straps hold
    task automatic do_reset(logic b, logic i);
        {pullBoot, pullIrq, flagDirection, rst_n} = {b, i, 4'hf, 1'h0};
        repeat (10) @(negedge core_clk);
        chk("oe", 12'h000, program_condition_oe);
        {rst_n, pullBoot, pullIrq} = {1'h1, !b, !i};
        repeat (3) @(negedge core_clk);
        chk("straps", {b, i, 2'h0}, straps);
        chk("boot", {!b, b}, {bootFromEprom, bootWaitExternal});
        chk("irqmode", {8{i}}, {irqEnabled, irqEdgeMode});
    endtask

    task automatic irq_run(logic en, logic edg);
        for (int k = 0; k < 4; k++)
        begin
            irqAssert = 4'h1 << k;
            @(negedge core_clk);
            chk("pend", {11'h0, en} << k, irqPending);
            irqAssert = 4'h0;
            @(negedge core_clk);
            chk("latch", {11'h0, en & edg} << k, irqPending);
            irqAck = 4'h1 << k;
            @(negedge core_clk);
            irqAck = 4'h0;
            chk("clear", 12'h000, irqPending);
        end
    endtask

    task automatic irq_cfg(logic [3:0] edg);
        {irqEnableSet, irqEdgeSet, irqConfigWrite} = {4'hf, edg, 1'h1};
        @(negedge core_clk);
        irqConfigWrite = 1'h0;
        chk("cfg", {4'hf, edg}, {irqEnabled, irqEdgeMode});
    endtask

    // A second expiry restarts the count
    task automatic pulse_run(int gap, int want);
        logic [11:0] n;
        n = 12'h000;
        for (int i = 0; i < 12; i++)
        begin
            timerZeroExpire = (i == 0 || i == gap);
            @(negedge core_clk);
            n += timer_zero_expired_out;
        end
        chk("pulse", 12'(want), n);
    endtask

    initial
    begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    initial
    begin
        {bad_count, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
        seed = 32'h0000_14d5;
        {irqConfigWrite, timerZeroExpire, irqAssert, irqAck} = 10'h000;
        {flagWriteValue, program_condition_in, linkTransmit} = 12'h000;
        {irqEnableSet, irqEdgeSet} = 8'h00;
        {impedance_select_pins, drive_strength_select} = 6'h37;
        do_reset(1'h1, 1'h1);
        irq_run(1'h1, 1'h1);
        do_reset(1'h0, 1'h0);
        irq_run(1'h0, 1'h0);
        irq_cfg(4'h0);
        irq_run(1'h1, 1'h0);
        irq_cfg(4'hf);
        irq_run(1'h1, 1'h1);
        // New edge and acknowledge together: the edge must stay pending
        {irqAssert, irqAck} = 8'h11;
        @(negedge core_clk);
        {irqAssert, irqAck} = 8'h01;
        chk("setwin", 12'h001, irqPending);
        @(negedge core_clk);
        irqAck = 4'h0;
        chk("ack", 12'h000, irqPending);
        for (int k = 0; k < 40; k++)
        begin
            impedance_select_pins = 3'(k);
            drive_strength_select = k < 8 ? 3'(7 - k) : 3'($random(seed));
            {linkTransmit, flagDirection} = 8'($random(seed));
            {flagWriteValue, program_condition_in} = 8'($random(seed));
            @(negedge core_clk);
            expDrive = exp_drv(impedance_select_pins, drive_strength_select);
            chk("drive", expDrive, drive);
            seenDir = {portUpperDirection, port_zero_direction_out};
            chk("dir", linkTransmit, seenDir);
            chk("flagoe", flagDirection, program_condition_oe);
            chk("fout", flagWriteValue, program_condition_out);
            chk("fin", program_condition_in, flagReadValue);
        end
        pulse_run(20, 4);
        pulse_run(1, 5);
        pulse_run(3, 7);
        report_and_stop();
    end
endmodule
